// File: logic/emc_pkg.sv
// package for the external memory bank controller: bank map, field codes,
// state encoding and reset values shared by the controller and its helpers.
// assumes one 100 MHz bus clock times every count in the block.
package emc_pkg;

	// ---------------------------------------------------------------
	// clock and bank map
	// ---------------------------------------------------------------
	localparam int EMC_CLK_PERIOD_NS = 10;
	localparam logic [2:0] EMC_LAST_FIXED_BANK = 3'h5;
	localparam logic [2:0] EMC_BANK6 = 3'h6;
	localparam logic [2:0] EMC_BANK7 = 3'h7;
	localparam logic [27:0] EMC_BANK6_BASE = 28'hc000000;
	// smallest size of banks 6/7 (2 MB); size code n means 2 MB << n
	localparam logic [26:0] EMC_SPAN_MIN = 27'h0200000;
	localparam logic [2:0] EMC_SIZE_MAX = 3'h4;
	// sdram bank-select bit for a 2 MB bank; one higher per size step
	localparam logic [4:0] EMC_BA_BASE_BIT = 5'h14;

	// ---------------------------------------------------------------
	// field codes
	// ---------------------------------------------------------------
	localparam logic [1:0] EMC_W8 = 2'h0;
	localparam logic [1:0] EMC_W16 = 2'h1;
	localparam logic [1:0] EMC_W32 = 2'h2;
	localparam logic [1:0] EMC_W_TEST = 2'h3;
	localparam logic [1:0] EMC_MT_SRAM = 2'h0;
	localparam logic [1:0] EMC_MT_EDO = 2'h1;
	localparam logic [1:0] EMC_MT_SDRAM = 2'h2;
	// narrowest dram column address is 8 bits, code adds to it
	localparam logic [4:0] EMC_COL_BITS_MIN = 5'h08;

	// ---------------------------------------------------------------
	// reset values and counts
	// ---------------------------------------------------------------
	localparam logic [1:0] EMC_BOOT_WIDTH_RST = 2'h0;
	localparam logic [1:0] EMC_STRAP_SETTLE = 2'h2;
	localparam logic [3:0] EMC_CNT_RST = 4'h0;

	typedef enum logic [7:0] {
		EMC_ST_IDLE = 8'h01,
		EMC_ST_ADDR_SETUP = 8'h02,
		EMC_ST_CS_SETUP = 8'h04,
		EMC_ST_ACCESS = 8'h08,
		EMC_ST_STROBE_HOLD = 8'h10,
		EMC_ST_ADDR_HOLD = 8'h20,
		EMC_ST_GRANTED = 8'h40,
		EMC_ST_SELF_REFRESH = 8'h80
	} emc_state_t;

	// 2-bit phase code: 0, 1, 2 or 4 clocks
	function automatic logic [3:0] emc_ph_cycles(input logic [1:0] code);
		logic [3:0] c;
		c = (code == 2'h3) ? 4'h4 : {2'h0, code};
		return c;
	endfunction

endpackage

// File: logic/emc_sync2.sv
// two-flop synchroniser for pins entering the bus clock domain.
// assumes the pin is a level; the first flop feeds only the second.
`timescale 1ns/1ps
module emc_sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_q;

	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			meta_q <= RST;
			q_out <= RST;
		end else begin
			meta_q <= d_in;
			q_out <= meta_q;
		end
	end
endmodule

// File: logic/emc_bank_decode.sv
// address to bank decoder: banks 0-5 fixed 32 MB, banks 6/7 of equal
// programmable size; bank 7 follows bank 6. assumes a 28-bit address.
`timescale 1ns/1ps
module emc_bank_decode import emc_pkg::*; (
	input wire logic [27:0] addr_in,
	input wire logic [2:0] size_in,
	input wire logic four_bank_in,
	output logic hit_out,
	output logic [2:0] bank_out,
	output logic [24:0] off_out,
	output logic [1:0] ba_out
);
	logic [2:0] sz;
	logic [26:0] span;
	logic [26:0] rel;
	logic [26:0] rel7;
	logic [4:0] top;

	// oversize codes clamp to 32 MB so the map never overlaps itself
	assign sz = (size_in > EMC_SIZE_MAX) ? EMC_SIZE_MAX : size_in;
	assign span = EMC_SPAN_MIN << sz;
	assign rel = {1'b0, addr_in[25:0]};
	assign rel7 = rel - span;
	assign top = EMC_BA_BASE_BIT + {2'h0, sz};

	always_comb begin
		if (addr_in[27:25] <= EMC_LAST_FIXED_BANK) begin
			hit_out = 1'b1;
			bank_out = addr_in[27:25];
			off_out = addr_in[24:0];
		end else if (rel < span) begin
			hit_out = 1'b1;
			bank_out = EMC_BANK6;
			off_out = rel[24:0];
		end else if (rel < (span << 1)) begin
			hit_out = 1'b1;
			bank_out = EMC_BANK7;
			off_out = rel7[24:0];
		end else begin
			hit_out = 1'b0;
			bank_out = 3'h0;
			off_out = 25'h0;
		end
	end

	// sdram internal bank select: top bit(s) of the bank size
	assign ba_out = four_bank_in ? {off_out[top], off_out[top - 5'h01]}
		: {1'b0, off_out[top]};
endmodule

// File: logic/emc_ctrl.sv
// external memory bank controller: eight chip-select banks, per-bank width
// and access timing, wait stretching, bus hand-over and self-refresh.
// assumes requests come from logic on sys_clk_in; all pins are synchronised.
//
// Function
// RQ1: eight 32 MB banks, 256 MB total, one chip select each; here banks 6 and 7 take the programmed size of 2 to 32 MB.
// RQ2: byte order selectable little or big endian.
// RQ3: each bank has its own 8, 16 or 32-bit bus width.
// RQ4: banks 0-5 static memory only; banks 6 and 7 may be EDO or SDRAM.
// RQ5: seven banks fixed base; bank 7 base moves with programmed size.
// RQ6: bank 6 at 0xc00_0000; bank 7 directly after bank 6.
// RQ7: software gives banks 6 and 7 equal size, 2 to 32 MB.
// RQ8: boot bank at zero, width from straps at reset; 11 is test mode.
// RQ9: software writes all thirteen control words in one 52-byte burst.
// RQ10: address pins shift right by 0, 1 or 2 with bus width.
// RQ11: sdram bank select is top bit or two of the bank size.
// RQ12: with wait enabled, strobe stretches while the wait pin is low.
// RQ13: wait pin is looked at from one cycle before access ends.
// RQ14: strobe releases on the clock after wait is seen high.
// RQ15: write strobe stretches and releases exactly like the read strobe.
// RQ16: low bus request pin makes the controller drive bus grant low.
// RQ17: while grant is low, address, data and controls float.
// RQ18: request released, grant goes high and the bus is driven again.
// RQ19: dram and sdram can be held in self-refresh.
// RQ20: dram row and column widths may be equal or unequal.
// RQ21: setup, strobe and hold counts programmable per bank.
// RQ22: every count is in bus clock cycles.
// RQ23: byte lane enable is the AND of byte write strobe and read strobe.
// RQ24: software sets wait enable and width per bank except boot bank.
// RQ25: wait pin is synchronised before it stretches a strobe.
`timescale 1ns/1ps
module emc_ctrl import emc_pkg::*; (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic [1:0] boot_width_strap_in,
	input wire logic big_endian_in,
	input wire logic [15:0] bank_width_in,
	input wire logic [7:0] wait_en_in,
	input wire logic [7:0] ub_lb_in,
	input wire logic [3:0] bank67_type_in,
	input wire logic [2:0] bank67_size_in,
	input wire logic sdram_four_bank_in,
	input wire logic [1:0] dram_col_bits_in,
	input wire logic [15:0] tacs_in,
	input wire logic [15:0] tcos_in,
	input wire logic [23:0] tacc_in,
	input wire logic [15:0] toch_in,
	input wire logic [15:0] tcah_in,
	input wire logic self_refresh_in,
	input wire logic req_valid_in,
	input wire logic req_write_in,
	input wire logic [27:0] req_addr_in,
	input wire logic [31:0] req_wdata_in,
	input wire logic [3:0] req_be_in,
	output logic req_ready_out,
	output logic resp_valid_out,
	output logic resp_error_out,
	output logic [31:0] resp_rdata_out,
	output logic [1:0] boot_width_out,
	output logic test_mode_out,
	output logic [24:0] mem_addr_out,
	output logic addr_oe_out,
	output logic [31:0] mem_data_out,
	output logic mem_data_oe_out,
	input wire logic [31:0] mem_data_in,
	output logic boot_bank_chip_select_n_out,
	output logic [7:1] bank_cs_n_out,
	output logic read_strobe_n_out,
	output logic write_strobe_n_out,
	output logic [3:0] byte_write_strobe_n_out,
	output logic [3:0] byte_lane_enable_n_out,
	output logic [1:0] dram_ras_n_out,
	output logic [1:0] dram_cas_n_out,
	output logic [1:0] sdram_ba_out,
	output logic sdram_cke_out,
	output logic ctrl_oe_out,
	input wire logic ext_wait_n_in,
	input wire logic ext_bus_request_n_in,
	output logic ext_bus_grant_n_out
);
	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic wait_s;
	logic breq_s;
	logic [1:0] strap_s;
	logic [31:0] rd_s;

	emc_sync2 #(.W(1), .RST(1'b1)) u_wait_sync ( // [RQ25]
		.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
		.d_in(ext_wait_n_in), .q_out(wait_s));
	emc_sync2 #(.W(1), .RST(1'b1)) u_breq_sync (
		.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
		.d_in(ext_bus_request_n_in), .q_out(breq_s));
	emc_sync2 #(.W(2), .RST(EMC_BOOT_WIDTH_RST)) u_strap_sync (
		.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
		.d_in(boot_width_strap_in), .q_out(strap_s));
	emc_sync2 #(.W(32), .RST(32'h0)) u_data_sync (
		.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
		.d_in(mem_data_in), .q_out(rd_s));

	// ---------------------------------------------------------------
	// state and request registers
	// ---------------------------------------------------------------
	emc_state_t st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic [27:0] addr_q;
	logic wr_q;
	logic [31:0] wdata_q;
	logic [3:0] be_q;
	logic [1:0] strap_cnt_q;
	logic strap_taken_q;
	logic [1:0] boot_width_q;

	// while idle the live request is decoded so no cycle is lost
	logic in_idle;
	logic [27:0] m_addr;
	logic m_wr;
	logic [31:0] m_wdata;
	logic [3:0] m_be;
	assign in_idle = (st_q == EMC_ST_IDLE);
	assign m_addr = in_idle ? req_addr_in : addr_q;
	assign m_wr = in_idle ? req_write_in : wr_q;
	assign m_wdata = in_idle ? req_wdata_in : wdata_q;
	assign m_be = in_idle ? req_be_in : be_q;

	// ---------------------------------------------------------------
	// bank decode and per-bank settings
	// ---------------------------------------------------------------
	logic hit;
	logic [2:0] bank;
	logic [24:0] off;
	logic [1:0] dec_ba;

	emc_bank_decode u_dec ( // [RQ1] [RQ5] [RQ6]
		.addr_in(m_addr), .size_in(bank67_size_in),
		.four_bank_in(sdram_four_bank_in), .hit_out(hit),
		.bank_out(bank), .off_out(off), .ba_out(dec_ba)); // [RQ11]

	logic [3:0] b_bit2;
	logic [4:0] b_bit3;
	logic [1:0] b_width;
	logic [1:0] b_type;
	logic [3:0] b_tacs, b_tcos, b_toch, b_tcah;
	logic [2:0] b_tacc;
	logic b_wait, b_ub, is_edo, is_sd;
	assign b_bit2 = {bank, 1'b0};
	assign b_bit3 = {2'h0, bank} * 5'h03;
	// boot bank ignores the programmable width field
	assign b_width = (bank == 3'h0) ? boot_width_q
		: bank_width_in[b_bit2 +: 2]; // [RQ3] [RQ8] [RQ24]
	assign b_type = (bank[2:1] == 2'h3)
		? bank67_type_in[{bank[0], 1'b0} +: 2] : EMC_MT_SRAM; // [RQ4]
	assign b_tacs = emc_ph_cycles(tacs_in[b_bit2 +: 2]); // [RQ21] [RQ22]
	assign b_tcos = emc_ph_cycles(tcos_in[b_bit2 +: 2]);
	assign b_toch = emc_ph_cycles(toch_in[b_bit2 +: 2]);
	assign b_tcah = emc_ph_cycles(tcah_in[b_bit2 +: 2]);
	assign b_tacc = tacc_in[b_bit3 +: 3];
	assign b_wait = wait_en_in[bank] && (bank != 3'h0); // [RQ24]
	assign b_ub = ub_lb_in[bank];
	assign is_edo = (b_type == EMC_MT_EDO);
	assign is_sd = b_type[1];

	// ---------------------------------------------------------------
	// access sequence
	// ---------------------------------------------------------------
	logic take;
	logic wait_ok;
	logic access_done;
	assign take = in_idle && req_valid_in && req_ready_out;
	// wait is looked at from the last count on; the synchroniser already
	// placed its sampling edge a cycle earlier [RQ13]
	assign wait_ok = !b_wait || wait_s; // [RQ12] [RQ15]
	assign access_done = (st_q == EMC_ST_ACCESS) && (cnt_q == 4'h0)
		&& wait_ok; // [RQ14]

	always_comb begin
		st_d = st_q;
		cnt_d = (cnt_q == 4'h0) ? 4'h0 : cnt_q - 4'h1;
		case (st_q)
		EMC_ST_IDLE: begin
			if (take && hit) begin
				if (b_tacs != 4'h0) begin
					st_d = EMC_ST_ADDR_SETUP;
					cnt_d = b_tacs - 4'h1;
				end else if (b_tcos != 4'h0) begin
					st_d = EMC_ST_CS_SETUP;
					cnt_d = b_tcos - 4'h1;
				end else begin
					st_d = EMC_ST_ACCESS;
					cnt_d = {1'b0, b_tacc};
				end
			end else if (!take && !breq_s) begin
				st_d = EMC_ST_GRANTED; // [RQ16]
			end else if (!take && self_refresh_in) begin
				st_d = EMC_ST_SELF_REFRESH; // [RQ19]
			end
		end
		EMC_ST_ADDR_SETUP: begin
			if (cnt_q == 4'h0 && b_tcos != 4'h0) begin
				st_d = EMC_ST_CS_SETUP;
				cnt_d = b_tcos - 4'h1;
			end else if (cnt_q == 4'h0) begin
				st_d = EMC_ST_ACCESS;
				cnt_d = {1'b0, b_tacc};
			end
		end
		EMC_ST_CS_SETUP: begin
			if (cnt_q == 4'h0) begin
				st_d = EMC_ST_ACCESS;
				cnt_d = {1'b0, b_tacc};
			end
		end
		EMC_ST_ACCESS: begin
			if (access_done && b_toch != 4'h0) begin
				st_d = EMC_ST_STROBE_HOLD;
				cnt_d = b_toch - 4'h1;
			end else if (access_done && b_tcah != 4'h0) begin
				st_d = EMC_ST_ADDR_HOLD;
				cnt_d = b_tcah - 4'h1;
			end else if (access_done) begin
				st_d = EMC_ST_IDLE;
			end
		end
		EMC_ST_STROBE_HOLD: begin
			if (cnt_q == 4'h0 && b_tcah != 4'h0) begin
				st_d = EMC_ST_ADDR_HOLD;
				cnt_d = b_tcah - 4'h1;
			end else if (cnt_q == 4'h0) begin
				st_d = EMC_ST_IDLE;
			end
		end
		EMC_ST_ADDR_HOLD: begin
			if (cnt_q == 4'h0)
				st_d = EMC_ST_IDLE;
		end
		EMC_ST_GRANTED: begin
			if (breq_s)
				st_d = EMC_ST_IDLE; // [RQ18]
		end
		EMC_ST_SELF_REFRESH: begin
			if (!self_refresh_in)
				st_d = EMC_ST_IDLE;
		end
		default: begin
			st_d = EMC_ST_IDLE;
			cnt_d = EMC_CNT_RST;
		end
		endcase
	end

	// ---------------------------------------------------------------
	// address shifting, lane steering and next pin values
	// ---------------------------------------------------------------
	logic [1:0] lane;
	logic half;
	logic [24:0] wa;
	logic [4:0] col_bits;
	logic [24:0] col_mask;
	logic [24:0] addr_d;
	logic [31:0] lane_wdata, lane_rdata;
	logic [3:0] lane_n;
	assign lane = big_endian_in ? ~m_addr[1:0] : m_addr[1:0]; // [RQ2]
	assign half = big_endian_in ? ~m_addr[1] : m_addr[1];
	assign wa = (b_width == EMC_W8) ? off
		: (b_width == EMC_W16) ? (off >> 1) : (off >> 2); // [RQ10]
	assign col_bits = EMC_COL_BITS_MIN + {3'h0, dram_col_bits_in};
	assign col_mask = ~(25'h1ffffff << col_bits);
	// row on the address pins until the column strobe phase [RQ20]
	assign addr_d = !is_edo ? wa : (st_d == EMC_ST_ACCESS)
		? (wa & col_mask) : (wa >> col_bits);
	assign lane_wdata = (b_width == EMC_W8)
		? {24'h0, m_wdata[{lane, 3'h0} +: 8]}
		: (b_width == EMC_W16) ? {16'h0, m_wdata[{half, 4'h0} +: 16]}
		: m_wdata;
	assign lane_n = (b_width == EMC_W8) ? {3'h7, ~m_be[lane]}
		: (b_width == EMC_W16) ? {2'h3, ~m_be[{half, 1'b0} +: 2]}
		: ~m_be;
	assign lane_rdata = (b_width == EMC_W8)
		? ({24'h0, rd_s[7:0]} << {lane, 3'h0})
		: (b_width == EMC_W16) ? ({16'h0, rd_s[15:0]} << {half, 4'h0})
		: rd_s;

	logic strobe_d, cs_act_d, busy_d, sr_d;
	logic [7:0] cs_n_d;
	logic [1:0] bsel67, edo67;
	logic oe_n_d, we_n_d;
	logic [3:0] wbe_n_d;
	assign strobe_d = (st_d == EMC_ST_ACCESS);
	assign cs_act_d = strobe_d || (st_d == EMC_ST_CS_SETUP)
		|| (st_d == EMC_ST_STROBE_HOLD);
	assign busy_d = cs_act_d || (st_d == EMC_ST_ADDR_SETUP)
		|| (st_d == EMC_ST_ADDR_HOLD);
	assign sr_d = (st_d == EMC_ST_SELF_REFRESH);
	assign cs_n_d = (cs_act_d && !is_edo) ? ~(8'h01 << bank) : 8'hff;
	assign bsel67 = {bank[0], ~bank[0]} & {2{is_edo}};
	assign edo67 = {bank67_type_in[3:2] == EMC_MT_EDO,
		bank67_type_in[1:0] == EMC_MT_EDO};
	assign oe_n_d = !(strobe_d && !m_wr);
	assign we_n_d = !(strobe_d && m_wr); // [RQ15]
	assign wbe_n_d = (strobe_d && m_wr) ? lane_n : 4'hf;

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			strap_cnt_q <= 2'h0;
			strap_taken_q <= 1'b0;
			boot_width_q <= EMC_BOOT_WIDTH_RST;
			test_mode_out <= 1'b0;
		end else if (!strap_taken_q && strap_cnt_q == EMC_STRAP_SETTLE) begin
			// straps caught once, after the synchroniser has filled
			strap_taken_q <= 1'b1;
			boot_width_q <= strap_s; // [RQ8]
			test_mode_out <= (strap_s == EMC_W_TEST);
		end else if (!strap_taken_q) begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
		end
	end
	assign boot_width_out = boot_width_q;

	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			st_q <= EMC_ST_IDLE;
			cnt_q <= EMC_CNT_RST;
			addr_q <= 28'h0;
			wr_q <= 1'b0;
			wdata_q <= 32'h0;
			be_q <= 4'h0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			if (take && hit) begin
				addr_q <= req_addr_in;
				wr_q <= req_write_in;
				wdata_q <= req_wdata_in;
				be_q <= req_be_in;
			end
		end
	end

	// pins are registered from the next state so each output is a flop
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			req_ready_out <= 1'b0;
			resp_valid_out <= 1'b0;
			resp_error_out <= 1'b0;
			resp_rdata_out <= 32'h0;
			mem_addr_out <= 25'h0;
			mem_data_out <= 32'h0;
			mem_data_oe_out <= 1'b0;
			addr_oe_out <= 1'b1;
			ctrl_oe_out <= 1'b1;
			ext_bus_grant_n_out <= 1'b1;
			{bank_cs_n_out, boot_bank_chip_select_n_out} <= 8'hff;
			read_strobe_n_out <= 1'b1;
			write_strobe_n_out <= 1'b1;
			byte_write_strobe_n_out <= 4'hf;
			byte_lane_enable_n_out <= 4'hf;
			dram_ras_n_out <= 2'h3;
			dram_cas_n_out <= 2'h3;
			sdram_ba_out <= 2'h0;
			sdram_cke_out <= 1'b1;
		end else begin
			req_ready_out <= (st_d == EMC_ST_IDLE) && breq_s
				&& !self_refresh_in && strap_taken_q;
			resp_valid_out <= (take && !hit) || (!in_idle
				&& st_d == EMC_ST_IDLE && st_q != EMC_ST_GRANTED
				&& st_q != EMC_ST_SELF_REFRESH);
			resp_error_out <= take && !hit;
			if (access_done && !m_wr)
				resp_rdata_out <= lane_rdata;
			mem_addr_out <= addr_d;
			mem_data_out <= lane_wdata;
			mem_data_oe_out <= busy_d && m_wr;
			addr_oe_out <= (st_d != EMC_ST_GRANTED); // [RQ17]
			ctrl_oe_out <= (st_d != EMC_ST_GRANTED); // [RQ17]
			ext_bus_grant_n_out <= (st_d != EMC_ST_GRANTED); // [RQ16] [RQ18]
			{bank_cs_n_out, boot_bank_chip_select_n_out} <= cs_n_d; // [RQ1]
			read_strobe_n_out <= oe_n_d;
			write_strobe_n_out <= we_n_d;
			byte_write_strobe_n_out <= wbe_n_d;
			byte_lane_enable_n_out <= b_ub ? (wbe_n_d & {4{oe_n_d}})
				: 4'hf; // [RQ23]
			dram_ras_n_out <= ~(({2{cs_act_d}} & bsel67)
				| ({2{sr_d}} & edo67)); // [RQ19]
			dram_cas_n_out <= ~(({2{strobe_d}} & bsel67)
				| ({2{sr_d}} & edo67));
			sdram_ba_out <= is_sd ? dec_ba : 2'h0; // [RQ11]
			sdram_cke_out <= !sr_d; // [RQ19]
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);

	property p_cs_onehot;
		$onehot0(~{bank_cs_n_out, boot_bank_chip_select_n_out});
	endproperty
	a_cs_onehot: assert property (p_cs_onehot) // [RQ1]
		else $error("more than one chip select active");

	property p_boot_width_fixed;
		strap_taken_q |=> $stable(boot_width_out);
	endproperty
	a_boot_width_fixed: assert property (p_boot_width_fixed) // [RQ8]
		else $error("boot width changed after capture");

	property p_addr_shift16;
		st_q == EMC_ST_ACCESS && b_width == EMC_W16 && !is_edo
			|-> mem_addr_out == (off >> 1);
	endproperty
	a_addr_shift16: assert property (p_addr_shift16) // [RQ10]
		else $error("16-bit bank address not shifted by one");

	property p_wait_stretch;
		st_q == EMC_ST_ACCESS && cnt_q == 4'h0 && b_wait && !wait_s
			|=> !(read_strobe_n_out && write_strobe_n_out);
	endproperty
	a_wait_stretch: assert property (p_wait_stretch) // [RQ12]
		else $error("strobe released while wait held low");

	property p_wait_release;
		access_done |=> read_strobe_n_out && write_strobe_n_out;
	endproperty
	a_wait_release: assert property (p_wait_release) // [RQ14]
		else $error("strobe not released after wait high");

	property p_grant_on_request;
		in_idle && !breq_s && !take |=> !ext_bus_grant_n_out;
	endproperty
	a_grant_on_request: assert property (p_grant_on_request) // [RQ16]
		else $error("bus grant not given on idle request");

	property p_float_while_granted;
		!ext_bus_grant_n_out |-> !ctrl_oe_out && !addr_oe_out
			&& !mem_data_oe_out;
	endproperty
	a_float_while_granted: assert property (p_float_while_granted) // [RQ17]
		else $error("bus driven while granted away");

	property p_grant_release;
		$rose(ext_bus_request_n_in) && !ext_bus_grant_n_out
			|-> ##[1:4] ext_bus_grant_n_out;
	endproperty
	a_grant_release: assert property (p_grant_release) // [RQ18]
		else $error("bus grant not released");

	property p_lane_and;
		byte_lane_enable_n_out != 4'hf |-> byte_lane_enable_n_out
			== (byte_write_strobe_n_out & {4{read_strobe_n_out}});
	endproperty
	a_lane_and: assert property (p_lane_and) // [RQ23]
		else $error("byte lane enable not the and of strobes");

	c_wait_stretch: cover property (st_q == EMC_ST_ACCESS && !wait_s
		&& b_wait ##1 access_done);
	c_bus_granted: cover property (!ext_bus_grant_n_out
		##[1:20] ext_bus_grant_n_out);
	c_self_refresh: cover property (!sdram_cke_out);
	c_unmapped: cover property (resp_error_out);
endmodule

// File: test/emc_mem_model.sv
// partner model: static memory on the strobe pins, with a wait pin.
// assumes the controller times everything on the rising bus clock.
`timescale 1ns/1ps
module emc_mem_model (
	input wire logic sys_clk_in,
	input wire logic [24:0] addr_in,
	input wire logic [31:0] data_in,
	input wire logic rd_n_in,
	input wire logic wr_n_in,
	input wire logic [3:0] wait_cyc_in,
	output logic [31:0] data_out,
	output logic ext_wait_n_out
);
	logic [31:0] mem [16];
	logic [31:0] last = 32'h0;
	logic [3:0] cnt = 4'h0;
	wire idle = rd_n_in !== 1'b0 && wr_n_in !== 1'b0;
	// a released bus shows the inverse of its last value, never a stale match
	assign data_out = rd_n_in === 1'b0 ? mem[addr_in[3:0]] : ~last;
	// wait held low for a set count of strobe cycles
	assign ext_wait_n_out = idle || cnt >= wait_cyc_in;
	always @(posedge sys_clk_in) begin
		cnt <= idle ? 4'h0 : cnt + 4'h1;
		if (rd_n_in === 1'b0) last <= mem[addr_in[3:0]];
		if (wr_n_in === 1'b0) mem[addr_in[3:0]] <= data_in;
	end
endmodule

// File: test/tb_emc_ctrl.sv
// testbench for the bank controller: map, widths, wait, hand-over, refresh.
// assumes one static memory model on the pins and idle straps of 32-bit.
`timescale 1ns/1ps
module tb_emc_ctrl import emc_pkg::*;;
	logic sys_clk_in, rstn_in, big_endian_in, self_refresh_in, req_valid_in;
	logic req_write_in, ext_wait_n_in, ext_bus_request_n_in, req_ready_out;
	logic resp_valid_out, resp_error_out, test_mode_out, addr_oe_out;
	logic mem_data_oe_out, boot_bank_chip_select_n_out, read_strobe_n_out;
	logic write_strobe_n_out, sdram_cke_out, ctrl_oe_out, ext_bus_grant_n_out;
	logic [1:0] boot_width_strap_in, boot_width_out;
	logic [2:0] bank67_size_in;
	logic [3:0] req_be_in, byte_write_strobe_n_out, byte_lane_enable_n_out;
	logic [3:0] wait_cyc;
	logic [7:0] wait_en_in, ub_lb_in;
	logic [7:1] bank_cs_n_out;
	logic [15:0] bank_width_in, tph;
	logic [23:0] tacc_in;
	logic [24:0] mem_addr_out;
	logic [27:0] req_addr_in;
	logic [31:0] req_wdata_in, resp_rdata_out, mem_data_out, mem_data_in;
	int fails, total_checks;
	wire [3:0] lane_exp = byte_write_strobe_n_out & {4{read_strobe_n_out}};
	emc_ctrl dut (.sys_clk_in, .rstn_in, .boot_width_strap_in, .big_endian_in,
		.bank_width_in, .wait_en_in, .ub_lb_in, .bank67_type_in(4'h0),
		.bank67_size_in, .sdram_four_bank_in(1'b0), .dram_col_bits_in(2'h0),
		.tacs_in(tph), .tcos_in(tph), .tacc_in, .toch_in(tph), .tcah_in(tph),
		.self_refresh_in, .req_valid_in, .req_write_in, .req_addr_in,
		.req_wdata_in, .req_be_in, .req_ready_out, .resp_valid_out,
		.resp_error_out, .resp_rdata_out, .boot_width_out, .test_mode_out,
		.mem_addr_out, .addr_oe_out, .mem_data_out, .mem_data_oe_out,
		.mem_data_in, .boot_bank_chip_select_n_out, .bank_cs_n_out,
		.read_strobe_n_out, .write_strobe_n_out, .byte_write_strobe_n_out,
		.byte_lane_enable_n_out, .dram_ras_n_out(), .dram_cas_n_out(),
		.sdram_ba_out(), .sdram_cke_out, .ctrl_oe_out, .ext_wait_n_in,
		.ext_bus_request_n_in, .ext_bus_grant_n_out);
	emc_mem_model u_mem (.sys_clk_in, .addr_in(mem_addr_out),
		.data_in(mem_data_out), .rd_n_in(read_strobe_n_out),
		.wr_n_in(write_strobe_n_out), .wait_cyc_in(wait_cyc),
		.data_out(mem_data_in), .ext_wait_n_out(ext_wait_n_in));
	always #5 sys_clk_in = ~sys_clk_in;
	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask
	task automatic final_report();
		if (fails == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic tmo(input int n);
		if (n >= 100) begin
			fails++;
			final_report();
		end
	endtask
	// one access; returns chip selects seen, last strobe address, strobe cycles
	task automatic acc(input logic wr, input logic [27:0] a,
		input logic [31:0] d, output logic [7:0] cs, output logic [24:0] ma,
		output int lo);
		int n;
		cs = 8'hff;
		ma = 25'h0;
		lo = 0;
		for (n = 0; n < 100 && req_ready_out !== 1'b1; n++) @(negedge sys_clk_in);
		tmo(n);
		req_valid_in = 1'b1;
		req_write_in = wr;
		req_addr_in = a;
		req_wdata_in = d;
		@(negedge sys_clk_in);
		req_valid_in = 1'b0;
		for (n = 0; n < 100 && resp_valid_out !== 1'b1; n++) begin
			cs = cs & {bank_cs_n_out, boot_bank_chip_select_n_out};
			if (!(read_strobe_n_out === 1'b1 && write_strobe_n_out === 1'b1)) begin
				lo++;
				ma = mem_addr_out;
			end
			chk("lane", 32'(lane_exp), 32'(byte_lane_enable_n_out));
			@(negedge sys_clk_in);
		end
		tmo(n);
	endtask
	task automatic s_map();
		logic [7:0] cs;
		logic [24:0] ma;
		logic [27:0] a;
		logic [1:0] w;
		int lo;
		for (int b = 0; b < 8; b++) begin
			a = (b == 7) ? 28'hc200010 : 28'(b) * 28'h2000000 + 28'h10;
			w = (b == 0) ? EMC_W32 : bank_width_in[2*b +: 2];
			acc(1'b1, a, 32'h5a000000 + 32'(b), cs, ma, lo);
			chk("cs", {24'h0, ~(8'h1 << b)}, 32'(cs));
			chk("addr", 32'h10 >> w, 32'(ma));
			chk("strobe", (b == 5) ? 32'h6 : 32'h3, 32'(lo));
			if (w == EMC_W32) begin
				acc(1'b0, a, 32'h0, cs, ma, lo);
				chk("rdata", 32'h5a000000 + 32'(b), resp_rdata_out);
			end
		end
		chk("boot_width", 32'(EMC_W32), 32'(boot_width_out));
		chk("test_mode", 32'h0, 32'(test_mode_out));
		bank67_size_in = 3'h4;
		acc(1'b0, 28'he000010, 32'h0, cs, ma, lo);
		chk("cs_top", 32'h7f, 32'(cs));
		acc(1'b0, 28'hdfffff0, 32'h0, cs, ma, lo);
		chk("cs_six", 32'hbf, 32'(cs));
		bank67_size_in = 3'h0;
		acc(1'b0, 28'hc400010, 32'h0, cs, ma, lo);
		chk("unmapped", 32'h3, 32'({resp_error_out, cs == 8'hff}));
	endtask
	task automatic s_wait_endian();
		logic [7:0] cs;
		logic [24:0] ma;
		int lo;
		wait_cyc = 4'h6;
		acc(1'b0, 28'h8000010, 32'h0, cs, ma, lo);
		chk("wait_rd", 32'h1, 32'(lo >= 7 && lo <= 10));
		acc(1'b1, 28'h8000010, 32'h0, cs, ma, lo);
		chk("wait_wr", 32'h1, 32'(lo >= 7 && lo <= 10));
		acc(1'b0, 28'h6000010, 32'h0, cs, ma, lo);
		chk("wait_off", 32'h3, 32'(lo));
		wait_cyc = 4'h0;
		big_endian_in = 1'b1;
		acc(1'b1, 28'h6000000, 32'ha1b2c3d4, cs, ma, lo);
		chk("big_lane", 32'ha1, 32'(u_mem.mem[0][7:0]));
		big_endian_in = 1'b0;
		acc(1'b1, 28'h6000001, 32'ha1b2c3d4, cs, ma, lo);
		chk("little_lane", 32'hc3, 32'(u_mem.mem[1][7:0]));
	endtask
	task automatic s_grant_sref();
		int n;
		ext_bus_request_n_in = 1'b0;
		for (n = 0; n < 100 && ext_bus_grant_n_out !== 1'b0; n++) @(negedge sys_clk_in);
		tmo(n);
		chk("float", 32'h0, 32'({addr_oe_out, ctrl_oe_out, mem_data_oe_out}));
		// the outside master ends its tenure
		ext_bus_request_n_in = 1'b1;
		for (n = 0; n < 100 && ext_bus_grant_n_out !== 1'b1; n++) @(negedge sys_clk_in);
		tmo(n);
		chk("drive", 32'h3, 32'({addr_oe_out, ctrl_oe_out}));
		self_refresh_in = 1'b1;
		repeat (2) @(negedge sys_clk_in);
		chk("cke", 32'h0, 32'({sdram_cke_out, req_ready_out}));
		self_refresh_in = 1'b0;
	endtask
	initial begin
		sys_clk_in = 1'b0;
		rstn_in = 1'b0;
		boot_width_strap_in = 2'h2;
		big_endian_in = 1'b0;
		// every control input is settled before the first access
		// per-bank widths and wait enables set by software
		bank_width_in = 16'haa24;
		wait_en_in = 8'h10;
		ub_lb_in = 8'hff;
		// one size shared by both dram-capable banks
		bank67_size_in = 3'h0;
		tph = 16'h0;
		tacc_in = {3'h2, 3'h2, 3'h5, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2};
		self_refresh_in = 1'b0;
		req_valid_in = 1'b0;
		req_write_in = 1'b0;
		req_addr_in = 28'h0;
		req_wdata_in = 32'h0;
		req_be_in = 4'hf;
		ext_bus_request_n_in = 1'b1;
		wait_cyc = 4'h0;
		fails = 0;
		total_checks = 0;
		repeat (3) @(negedge sys_clk_in);
		rstn_in = 1'b1;
		s_map();
		s_wait_endian();
		s_grant_sref();
		final_report();
	end
endmodule
